// ==== hdl/drp_memory_port.sv ====
// Purpose: pin-level DRAM and ROM/flash access sequencer
// Assumes: requests come from logic on mclk; read data is sampled via two flops
// Notes: one access at a time; byte lane 0 is pin data bits 0..7 (the msb byte)
`timescale 1ns/1ps
module drp_memory_port #(
    parameter int SETUP_CYC = drp_pkg::SETUP_CYC,
    parameter int RCD_CYC = drp_pkg::RCD_CYC,
    parameter int CAS_CYC = drp_pkg::CAS_CYC,
    parameter int RP_CYC = drp_pkg::RP_CYC,
    parameter int ROM_CYC = drp_pkg::ROM_CYC,
    parameter int REC_CYC = drp_pkg::REC_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire drp_pkg::drp_req_t req,
    input wire logic reqValid,
    output logic reqReady,
    output logic rspValid,
    output logic [31:0] rspData,
    output logic [0:3] rasN,
    output logic [0:3] casN,
    output logic weN,
    output logic [0:3] rom_bank_select_n,
    output logic rom_high_addr_latch,
    output logic flash_write_en_n,
    output logic rom_output_en_n,
    output logic [0:11] mem_addr_bus,
    input wire logic [0:31] mem_data_bus_in,
    output logic [0:31] mem_data_bus_out,
    output logic mem_data_bus_oe_n
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    initial begin
        if (SETUP_CYC < 1 || RCD_CYC < 1 || RP_CYC < 1 || REC_CYC < 1 ||
            CAS_CYC < drp_pkg::MIN_STROBE_CYC || ROM_CYC < drp_pkg::MIN_STROBE_CYC ||
            CAS_CYC > 255 || ROM_CYC > 255 || RP_CYC > 255 || RCD_CYC > 255 ||
            SETUP_CYC > 255 || REC_CYC > 255) begin
            $error("drp_memory_port: timing count out of range");
        end
    end

    function automatic logic [0:3] bankSel(input logic [1:0] b);
        logic [0:3] s;
        s = drp_pkg::STROBES_OFF;
        s[b] = 1'b0;
        return s;
    endfunction

    drp_pkg::drp_state_t state;
    drp_pkg::drp_state_t next_state;
    drp_pkg::drp_req_t cur;
    drp_pkg::drp_req_t op;
    logic [drp_pkg::CNT_W-1:0] cnt;
    logic [drp_pkg::CNT_W-1:0] limit;
    logic stepDone;
    logic take;
    logic [0:31] mdMeta;
    logic [0:31] mdSync;

    // ------------------------------------------------------------
    // reset: asserts at once, releases on mclk so no flop sees a late edge
    // ------------------------------------------------------------
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rstMeta <= 1'b1;
            rstSync <= 1'b1;
        end else begin
            rstMeta <= 1'b0;
            rstSync <= rstMeta;
        end
    end

    assign take = reqValid && reqReady;
    assign op = take ? req : cur;
    assign stepDone = (cnt == limit);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        unique case (state)
            drp_pkg::ST_DR_ROW, drp_pkg::ST_DR_COL, drp_pkg::ST_ROM_LO:
                limit = drp_pkg::CNT_W'(SETUP_CYC - 1);
            drp_pkg::ST_DR_RAS: limit = drp_pkg::CNT_W'(RCD_CYC - 1);
            drp_pkg::ST_DR_CAS: limit = drp_pkg::CNT_W'(CAS_CYC - 1);
            drp_pkg::ST_DR_PRE: limit = drp_pkg::CNT_W'(RP_CYC - 1);
            drp_pkg::ST_ROM_ACC: limit = drp_pkg::CNT_W'(ROM_CYC - 1);
            drp_pkg::ST_ROM_REC: limit = drp_pkg::CNT_W'(REC_CYC - 1);
            default: limit = '0;
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            drp_pkg::ST_IDLE: begin
                if (take) begin
                    next_state = req.rom ? drp_pkg::ST_ROM_HI : drp_pkg::ST_DR_ROW;
                end
            end
            drp_pkg::ST_DR_ROW: if (stepDone) next_state = drp_pkg::ST_DR_RAS;
            drp_pkg::ST_DR_RAS: if (stepDone) next_state = drp_pkg::ST_DR_COL;
            drp_pkg::ST_DR_COL: if (stepDone) next_state = drp_pkg::ST_DR_CAS;
            drp_pkg::ST_DR_CAS: if (stepDone) next_state = drp_pkg::ST_DR_PRE;
            drp_pkg::ST_DR_PRE: if (stepDone) next_state = drp_pkg::ST_IDLE;
            drp_pkg::ST_ROM_HI: next_state = drp_pkg::ST_ROM_LO;
            drp_pkg::ST_ROM_LO: if (stepDone) next_state = drp_pkg::ST_ROM_ACC;
            drp_pkg::ST_ROM_ACC: if (stepDone) next_state = drp_pkg::ST_ROM_REC;
            drp_pkg::ST_ROM_REC: if (stepDone) next_state = drp_pkg::ST_IDLE;
            default: next_state = drp_pkg::ST_IDLE;
        endcase
    end

    // reset is the processor's, active high
    always_ff @(posedge mclk or posedge rstSync) begin
        if (rstSync) begin
            state <= drp_pkg::ST_IDLE;
            cnt <= '0;
            cur <= '0;
            reqReady <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= (next_state != state) ? '0 : cnt + 1'b1;
            if (take) begin
                cur <= req;
            end
            reqReady <= (next_state == drp_pkg::ST_IDLE) && !take;
        end
    end

    // ------------------------------------------------------------
    // DRAM strobes, driven from next_state so pins are registered
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rstSync) begin
        if (rstSync) begin
            rasN <= drp_pkg::STROBES_OFF;
            casN <= drp_pkg::STROBES_OFF;
            weN <= 1'b1;
        end else begin
            // only the requested bank ever goes low
            rasN <= (next_state inside {drp_pkg::ST_DR_RAS, drp_pkg::ST_DR_COL,
                    drp_pkg::ST_DR_CAS}) ? bankSel(op.bank) : drp_pkg::STROBES_OFF;
            casN <= (next_state == drp_pkg::ST_DR_CAS) ? ~op.byteEn
                    : drp_pkg::STROBES_OFF;
            // early write: enable is low before the column strobe falls
            weN <= !(op.write && next_state inside {drp_pkg::ST_DR_COL,
                    drp_pkg::ST_DR_CAS});
        end
    end

    // ------------------------------------------------------------
    // ROM / flash controls
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rstSync) begin
        if (rstSync) begin
            rom_bank_select_n <= drp_pkg::STROBES_OFF;
            rom_high_addr_latch <= 1'b0;
            flash_write_en_n <= 1'b1;
            rom_output_en_n <= 1'b1;
        end else begin
            rom_bank_select_n <= (next_state inside {drp_pkg::ST_ROM_LO,
                    drp_pkg::ST_ROM_ACC}) ? bankSel(op.bank) : drp_pkg::STROBES_OFF;
            rom_high_addr_latch <= (next_state == drp_pkg::ST_ROM_HI);
            flash_write_en_n <= !(op.write && next_state == drp_pkg::ST_ROM_ACC);
            rom_output_en_n <= !(!op.write && next_state == drp_pkg::ST_ROM_ACC);
        end
    end

    // ------------------------------------------------------------
    // address bus: row/high half first, column/low half after
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rstSync) begin
        if (rstSync) begin
            mem_addr_bus <= drp_pkg::ADDR_RST;
        end else begin
            unique case (next_state)
                drp_pkg::ST_DR_ROW, drp_pkg::ST_DR_RAS, drp_pkg::ST_ROM_HI:
                    mem_addr_bus <= op.addr[23:12];
                drp_pkg::ST_DR_COL, drp_pkg::ST_DR_CAS, drp_pkg::ST_ROM_LO,
                drp_pkg::ST_ROM_ACC, drp_pkg::ST_ROM_REC:
                    mem_addr_bus <= op.addr[11:0];
                default: mem_addr_bus <= mem_addr_bus;
            endcase
        end
    end

    // ------------------------------------------------------------
    // shared data bus
    // ------------------------------------------------------------
    // data held one state past the write strobe for hold time
    always_ff @(posedge mclk or posedge rstSync) begin
        if (rstSync) begin
            mem_data_bus_out <= drp_pkg::DATA_RST;
            mem_data_bus_oe_n <= 1'b1;
        end else begin
            mem_data_bus_out <= op.wdata;
            mem_data_bus_oe_n <= !(op.write && next_state inside {drp_pkg::ST_DR_COL,
                    drp_pkg::ST_DR_CAS, drp_pkg::ST_DR_PRE, drp_pkg::ST_ROM_LO,
                    drp_pkg::ST_ROM_ACC, drp_pkg::ST_ROM_REC});
        end
    end

    // pin data is asynchronous to us, so two flops before use
    always_ff @(posedge mclk or posedge rstSync) begin
        if (rstSync) begin
            mdMeta <= drp_pkg::DATA_RST;
            mdSync <= drp_pkg::DATA_RST;
        end else begin
            mdMeta <= mem_data_bus_in;
            mdSync <= mdMeta;
        end
    end

    // sample at the last strobe cycle, after the sync latency
    always_ff @(posedge mclk or posedge rstSync) begin
        if (rstSync) begin
            rspValid <= 1'b0;
            rspData <= drp_pkg::DATA_RST;
        end else begin
            rspValid <= 1'b0;
            if (!cur.write && stepDone &&
                (state == drp_pkg::ST_DR_CAS || state == drp_pkg::ST_ROM_ACC)) begin
                rspValid <= 1'b1;
                rspData <= mdSync;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence romHighCycle;
        rom_high_addr_latch && mem_addr_bus == cur.addr[23:12] && &rom_bank_select_n;
    endsequence

    sequence romLowCycle;
        !rom_high_addr_latch && mem_addr_bus == cur.addr[11:0] && !(&rom_bank_select_n);
    endsequence

    ras_single_bank_a: assert property (@(posedge mclk) disable iff (rst)
        $countones(~rasN) <= 1 && (&rasN || rasN == bankSel(cur.bank)))
        else $error("row strobe low on more than the selected bank");

    ras_row_setup_a: assert property (@(posedge mclk) disable iff (rst)
        (!(&rasN) && $past(&rasN)) |-> $stable(mem_addr_bus) && mem_addr_bus == cur.addr[23:12])
        else $error("row strobe fell without a settled row address");

    cas_col_setup_a: assert property (@(posedge mclk) disable iff (rst)
        (!(&casN) && $past(&casN)) |-> !(&rasN) && $stable(mem_addr_bus) &&
        mem_addr_bus == cur.addr[11:0] && casN == ~cur.byteEn)
        else $error("column strobe fell without row open or column address");

    cas_pulse_len_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(casN[0]) |-> (!casN[0])[*3])
        else $error("column strobe pulse too short");

    dram_write_en_a: assert property (@(posedge mclk) disable iff (rst)
        !weN |-> cur.write && !cur.rom && !mem_data_bus_oe_n && !(&rasN))
        else $error("DRAM write enable outside a DRAM write");

    rom_two_cycle_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(rom_high_addr_latch) |-> romHighCycle ##1 romLowCycle)
        else $error("ROM address halves out of order");

    rom_select_bank_a: assert property (@(posedge mclk) disable iff (rst)
        !(&rom_bank_select_n) |-> cur.rom && rom_bank_select_n == bankSel(cur.bank) && &rasN)
        else $error("ROM bank select wrong or overlapping DRAM");

    flash_write_a: assert property (@(posedge mclk) disable iff (rst)
        !flash_write_en_n |-> cur.write && !(&rom_bank_select_n) && rom_output_en_n &&
        !mem_data_bus_oe_n)
        else $error("flash write enable outside a ROM write");

    rom_read_oe_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(rom_output_en_n) |-> (!cur.write && mem_data_bus_oe_n && !rom_output_en_n)[*3])
        else $error("ROM output enable during a drive or too short");

    bus_contention_a: assert property (@(posedge mclk) disable iff (rst)
        !mem_data_bus_oe_n |-> cur.write && rom_output_en_n)
        else $error("data bus driven during a read");

    reset_idle_a: assert property (@(posedge mclk)
        $fell(rst) |-> &rasN && &casN && weN && &rom_bank_select_n && mem_data_bus_oe_n)
        else $error("pins not idle after reset");

    // no page mode: row and column strobes rise together
    ras_cas_release_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(&casN) |-> &rasN)
        else $error("row strobe held past the column strobe");

    // early write keeps the data pins out of a read turnaround
    early_write_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(weN) |-> &casN && !(&rasN))
        else $error("write enable fell after the column strobe");

    latch_one_cycle_a: assert property (@(posedge mclk) disable iff (rst)
        rom_high_addr_latch |=> !rom_high_addr_latch)
        else $error("address latch enable held past the first ROM cycle");

    rsp_after_strobe_a: assert property (@(posedge mclk) disable iff (rst)
        rspValid |-> !cur.write && &casN && rom_output_en_n)
        else $error("read answer while a strobe is still low");

endmodule

// ==== hdl/drp_pkg.sv ====
// Purpose: shared constants and types for the DRAM / ROM memory port
// Assumes: single 250 MHz clock; pin buses numbered with bit 0 as the msb
// Notes: timing figures are plain defaults, tune them to the fitted parts
package drp_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int BANKS = 4;
    localparam int LANES = 4;
    localparam int MA_W = 12;
    localparam int MD_W = 32;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // timing, figures in ns, counts derived from the clock rate
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int T_ADDR_SETUP_NS = 8;
    localparam int T_RCD_NS = 20;
    localparam int T_CAS_NS = 16;
    localparam int T_RP_NS = 40;
    localparam int T_ROM_ACC_NS = 100;
    localparam int T_ROM_REC_NS = 12;
    // least times, so round up
    localparam int SETUP_CYC = (T_ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
    localparam int CAS_CYC = (T_CAS_NS * CLK_MHZ + 999) / 1000;
    localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int ROM_CYC = (T_ROM_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC = (T_ROM_REC_NS * CLK_MHZ + 999) / 1000;
    // the read sample passes two pin flops, strobes must outlast them
    localparam int MIN_STROBE_CYC = 3;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [3:0] STROBES_OFF = 4'hF;
    localparam logic [11:0] ADDR_RST = 12'h000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_IDLE, ST_DR_ROW, ST_DR_RAS, ST_DR_COL, ST_DR_CAS, ST_DR_PRE,
        ST_ROM_HI, ST_ROM_LO, ST_ROM_ACC, ST_ROM_REC
    } drp_state_t;

    // one access request from the processor side
    typedef struct packed {
        logic write;
        logic rom;
        logic [1:0] bank;
        logic [3:0] byteEn;
        logic [23:0] addr;
        logic [31:0] wdata;
    } drp_req_t;

endpackage

// ==== tb/drp_mem_model.sv ====
// Purpose: behavioural DRAM banks and ROM/flash banks behind the memory port pins
// Assumes: pins sampled on rising mclk; strobes already registered by the port
// Notes: undriven data bus shows the inverse of its last level, never a held value
`timescale 1ns/1ps
module drp_mem_model (
    input wire logic mclk,
    input wire logic [0:3] rasN,
    input wire logic [0:3] casN,
    input wire logic weN,
    input wire logic [0:3] rom_bank_select_n,
    input wire logic rom_high_addr_latch,
    input wire logic flash_write_en_n,
    input wire logic rom_output_en_n,
    input wire logic [0:11] mem_addr_bus,
    input wire logic [0:31] mem_data_bus_out,
    input wire logic mem_data_bus_oe_n,
    output logic [0:31] mem_data_bus_in
);
    logic [31:0] mem [bit [26:0]];
    logic [11:0] rowLat [4];
    logic [11:0] highLat = 12'h000;
    logic [0:3] prevRas = 4'hF;
    logic [0:3] prevCas = 4'hF;
    logic prevFwe = 1'b1;
    logic [1:0] ramBank, romBank;
    logic [31:0] busLvl, lastLvl = 32'h0000_0000, rdWord, w;
    logic driving;

    function automatic logic [31:0] rd(input logic [26:0] k);
        return mem.exists(k) ? mem[k] : 32'h0000_0000;
    endfunction

    // --------------------------------
    // pin decode and bus level
    // --------------------------------
    always @* begin
        ramBank = 2'h0;
        romBank = 2'h0;
        for (int b = 0; b < 4; b++) begin
            if (!rasN[b]) ramBank = 2'(b);
            if (!rom_bank_select_n[b]) romBank = 2'(b);
        end
        driving = 1'b0;
        rdWord = 32'h0000_0000;
        if (!rasN[ramBank] && casN != 4'hF && weN) begin
            driving = 1'b1;
            rdWord = rd({1'b0, ramBank, rowLat[ramBank], mem_addr_bus});
        end else if (!rom_bank_select_n[romBank] && !rom_output_en_n) begin
            driving = 1'b1;
            rdWord = rd({1'b1, romBank, highLat, mem_addr_bus});
        end
        // port and memory share one wire; port wins when enabled
        busLvl = !mem_data_bus_oe_n ? mem_data_bus_out : (driving ? rdWord : ~lastLvl);
        mem_data_bus_in = busLvl;
    end

    // --------------------------------
    // latching and writes
    // --------------------------------
    always @(posedge mclk) begin
        prevRas <= rasN;
        prevCas <= casN;
        prevFwe <= flash_write_en_n;
        lastLvl <= busLvl;
        for (int b = 0; b < 4; b++) begin
            if (prevRas[b] && !rasN[b]) rowLat[b] <= mem_addr_bus;
        end
        if (rom_high_addr_latch) highLat <= mem_addr_bus;
        if (!weN && prevCas == 4'hF && casN != 4'hF) begin
            w = rd({1'b0, ramBank, rowLat[ramBank], mem_addr_bus});
            for (int l = 0; l < 4; l++) begin
                if (!casN[l]) w[31-8*l -: 8] = busLvl[31-8*l -: 8];
            end
            mem[{1'b0, ramBank, rowLat[ramBank], mem_addr_bus}] = w;
        end
        if (prevFwe && !flash_write_en_n && !rom_bank_select_n[romBank]) begin
            mem[{1'b1, romBank, highLat, mem_addr_bus}] = busLvl;
        end
    end
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the DRAM / ROM memory port
// Assumes: short timing parameters; the partner model stands for all memory
// Notes: expected read data comes from a bench-side shadow, never from the port
`timescale 1ns/1ps
module tb;
    localparam int S = 1, R = 1, C = 3, P = 1, RM = 3, RC = 1;
    localparam int DR_LAT = S + R + S + C;
    localparam int ROM_LAT = 1 + S + RM;
    logic mclk, rst, reqValid, reqReady, rspValid, weN, latchHi, fweN, roeN, oeN;
    logic [31:0] rspData, a, d, r;
    logic [0:3] rasN, casN, selN;
    logic [0:11] maBus;
    logic [0:31] mdIn, mdOut;
    drp_pkg::drp_req_t req;
    logic [31:0] seed = 32'hB3F53E04;
    logic [31:0] shadow [bit [26:0]];
    logic [31:0] expQ [$];
    int dueQ [$];
    int fail_count = 0, n_checks = 0, cyc = 0;

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

    drp_memory_port #(.SETUP_CYC(S), .RCD_CYC(R), .CAS_CYC(C), .RP_CYC(P),
        .ROM_CYC(RM), .REC_CYC(RC)) i_dut (.mclk(mclk), .rst(rst), .req(req),
        .reqValid(reqValid), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
        .rasN(rasN), .casN(casN), .weN(weN), .rom_bank_select_n(selN),
        .rom_high_addr_latch(latchHi), .flash_write_en_n(fweN), .rom_output_en_n(roeN),
        .mem_addr_bus(maBus), .mem_data_bus_in(mdIn), .mem_data_bus_out(mdOut),
        .mem_data_bus_oe_n(oeN));

    drp_mem_model i_mem (.mclk(mclk), .rasN(rasN), .casN(casN), .weN(weN),
        .rom_bank_select_n(selN), .rom_high_addr_latch(latchHi), .flash_write_en_n(fweN),
        .rom_output_en_n(roeN), .mem_addr_bus(maBus), .mem_data_bus_out(mdOut),
        .mem_data_bus_oe_n(oeN), .mem_data_bus_in(mdIn));

    function automatic logic [31:0] nextRand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // one access: held until taken, expectation noted for the watcher
    task automatic access(input logic wr, input logic rom, input logic [1:0] bank,
                          input logic [3:0] be, input logic [23:0] addr, input logic [31:0] wd);
        int n;
        logic [26:0] key;
        logic [31:0] w;
        key = {rom, bank, addr};
        @(negedge mclk);
        req = '{wr, rom, bank, be, addr, wd};
        reqValid = 1'b1;
        n = 0;
        while (reqReady !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n == 200) begin
            fail_count++;
            close_out();
        end
        @(negedge mclk);
        reqValid = 1'b0;
        w = shadow.exists(key) ? shadow[key] : 32'h0000_0000;
        if (!wr) begin
            expQ.push_back(w);
            dueQ.push_back(cyc + (rom ? ROM_LAT : DR_LAT));
        end else begin
            // enable bit l covers write data byte l
            for (int l = 0; l < 4; l++) begin
                if (rom || be[l]) w[8*l+7 -: 8] = wd[8*l+7 -: 8];
            end
            shadow[key] = w;
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) cyc <= cyc + 1;

    // --------------------------------
    // watcher
    // --------------------------------
    always @(negedge mclk) begin
        logic [31:0] expW;
        int due;
        if (!rst && rasN !== 4'hF) begin
            `CHK($countones(~rasN), 1)
            if (weN === 1'b0) `CHK(oeN, 1'b0)
        end
        if (rspValid === 1'b1) begin
            if (expQ.size() == 0) `CHK(rspValid, 1'b0)
            else begin
                expW = expQ.pop_front();
                due = dueQ.pop_front();
                `CHK(rspData, expW)
                `CHK(cyc, due)
            end
        end
    end

    initial begin
        int n;
        rst = 1'b1;
        reqValid = 1'b0;
        req = '0;
        repeat (10) @(negedge mclk);
        `CHK({rasN, casN, weN, selN, latchHi, fweN, roeN, oeN, reqReady, rspValid}, 19'h7FFDC)
        `CHK({maBus, mdOut, rspData}, 76'h0)
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        $display("test reset done");
        for (int b = 0; b < 4; b++) begin
            a = nextRand();
            access(1'b1, 1'b0, 2'(b), 4'hF, a[23:0], nextRand());
            access(1'b0, 1'b0, 2'(b), 4'hF, a[23:0], 32'h0000_0000);
        end
        $display("test dram banks done");
        a = nextRand();
        access(1'b1, 1'b0, 2'h2, 4'hF, a[23:0], nextRand());
        for (int l = 0; l < 4; l++) begin
            access(1'b1, 1'b0, 2'h2, 4'h1 << l, a[23:0], nextRand());
            access(1'b0, 1'b0, 2'h2, 4'hF, a[23:0], 32'h0000_0000);
        end
        $display("test byte lanes done");
        for (int b = 0; b < 4; b++) begin
            a = nextRand();
            access(1'b1, 1'b1, 2'(b), a[27:24], a[23:0], nextRand());
            access(1'b1, 1'b1, 2'(b), 4'hF, a[23:0] ^ 24'h800001, nextRand());
            access(1'b0, 1'b1, 2'(b), 4'hF, a[23:0], 32'h0000_0000);
        end
        $display("test rom banks done");
        for (int i = 0; i < 60; i++) begin
            r = nextRand();
            // a read with no lane enabled never strobes a column
            access(r[0], r[1], r[3:2], (r[0] || r[7:4] != 4'h0) ? r[7:4] : 4'hF,
                   {10'h0, r[9:8], 10'h0, r[11:10]}, nextRand());
        end
        n = 0;
        while (expQ.size() != 0 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        if (n == 100) fail_count++;
        $display("test random mix done");
        close_out();
    end
endmodule
